// [rtl/scan_port_pkg.sv]
package scan_port_pkg;

    // ---------------------------------------------------------------
    // Controller states
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR,
        ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } tap_state_t;

    // ---------------------------------------------------------------
    // Instruction codes and widths
    // ---------------------------------------------------------------
    localparam int          INSTR_W       = 3;
    localparam int          ID_W          = 32;
    localparam logic [2:0]  INS_EXTEST    = 3'h0;
    localparam logic [2:0]  INS_IDCODE    = 3'h1;
    localparam logic [2:0]  INS_SAMPLE_Z  = 3'h2;
    localparam logic [2:0]  INS_SAMPLE    = 3'h4;
    localparam logic [2:0]  INS_BYPASS    = 3'h7;
    localparam logic [2:0]  INS_RESET_VAL = INS_IDCODE;
    localparam logic [1:0]  IR_CAPTURE    = 2'h1;
    localparam int          FIFO_DEPTH    = 8;
    localparam int          RESET_EDGES   = 5;

    // ---------------------------------------------------------------
    // Pin group sampled by the system clock
    // ---------------------------------------------------------------
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } scan_pins_t;

    // One captured rising-edge event: mode select and data in
    typedef struct packed {
        logic tms;
        logic tdi;
    } scan_event_t;

endpackage

// [rtl/scan_sync.sv]
`timescale 1ns/10ps
module scan_sync
    import scan_port_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire scan_pins_t pins_in,
    output scan_pins_t      pins_out
);

    // ---------------------------------------------------------------
    // Two-stage synchroniser; first stage read only by the second
    // ---------------------------------------------------------------
    scan_pins_t meta_q;
    scan_pins_t sync_q;

    // Reset level high on mode select and data in mirrors the pull-ups
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            meta_q <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
            sync_q <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
        end
        else
        begin
            meta_q <= pins_in;
            sync_q <= meta_q;
        end
    end

    assign pins_out = sync_q;

endmodule // scan_sync

// [rtl/scan_fifo.sv]
`timescale 1ns/10ps
module scan_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("scan_fifo: DEPTH must be a power of two >= 2");
    end

    // ---------------------------------------------------------------
    // Storage and pointers
    // ---------------------------------------------------------------
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem_q[rd_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem_q[wr_q[AW-1:0]] <= in_data;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            wr_q <= '0;
        else if (push)
            wr_q <= wr_q + (AW+1)'(1);
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            rd_q <= '0;
        else if (pop)
            rd_q <= rd_q + (AW+1)'(1);
    end

endmodule // scan_fifo

// [rtl/boundary_scan_test_port.sv]
`timescale 1ns/10ps
module boundary_scan_test_port
    import scan_port_pkg::*;
#(
    parameter int          BSR_W        = 8,
    parameter bit          HAS_TEST_PORT = 1'b1,
    parameter logic [31:0] ID_CODE      = 32'h0000_0001  // Arbitrary value
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic             tck,
    input  wire logic             tms,
    input  wire logic             tdi,
    input  wire logic [BSR_W-1:0] ring_in,
    output logic                  tdo_o,
    output logic                  tdo_oe,
    output logic                  outputs_hiz,
    output logic                  test_reset
);

    initial
    begin
        if (BSR_W < 2)
            $error("boundary_scan_test_port: BSR_W must be at least 2");
        if (INSTR_W != 3)
            $error("boundary_scan_test_port: instruction decode assumes three bits");
    end

    // ---------------------------------------------------------------
    // Pin sampling and test clock edge detection
    // ---------------------------------------------------------------
    scan_pins_t  pins_s;
    scan_event_t ev_data;
    scan_event_t ev;
    logic        tck_prev_q;
    logic        rise;
    logic        fall;
    logic        ev_valid;
    logic        ev_take;
    logic        fifo_ready;

    // Floating inputs arrive high through the pads, so tie-offs read 1
    scan_sync u_sync (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .pins_in  ('{tck: tck, tms: tms, tdi: tdi}),
        .pins_out (pins_s)
    );

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            tck_prev_q <= 1'b0;
        else
            tck_prev_q <= pins_s.tck;
    end

    assign rise    = pins_s.tck && !tck_prev_q;
    assign fall    = !pins_s.tck && tck_prev_q;
    assign ev_data = '{tms: pins_s.tms, tdi: pins_s.tdi};

    // Rising edges queue their samples; the controller drains one per
    // event, but only once the previous falling edge has updated the output.
    // A full queue drops edges, which only happens far above 20 MHz.
    scan_fifo #(
        .WIDTH (2),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_valid  (rise),
        .in_ready  (fifo_ready),
        .in_data   (ev_data),
        .out_valid (ev_valid),
        .out_ready (ev_take),
        .out_data  (ev)
    );

    // ---------------------------------------------------------------
    // Controller
    // ---------------------------------------------------------------
    tap_state_t state_q;
    tap_state_t state_d;
    logic       fall_pend_q;
    logic [2:0] tms_hi_q;
    logic       port_on;

    assign port_on = HAS_TEST_PORT;
    // Each rising edge is processed, then output waits for its falling edge
    assign ev_take = ev_valid && !fall_pend_q && port_on;

    function automatic tap_state_t next_state(input tap_state_t s, input logic m);
        case (s)
            ST_RESET:    next_state = m ? ST_RESET    : ST_IDLE;
            ST_IDLE:     next_state = m ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   next_state = m ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = m ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = m ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = m ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   next_state = m ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   next_state = m ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = m ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = m ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = m ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   next_state = m ? ST_SEL_DR   : ST_IDLE;
            default:     next_state = ST_RESET;
        endcase
    endfunction

    always_comb
    begin
        state_d = next_state(state_q, ev.tms);
        // Five highs in a row always land in reset, whatever the state
        if (ev.tms && tms_hi_q == 3'(RESET_EDGES - 1))
            state_d = ST_RESET;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            state_q <= ST_RESET;
        else if (ev_take)
            state_q <= state_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            tms_hi_q <= 3'h0;
        else if (ev_take)
            tms_hi_q <= !ev.tms ? 3'h0 : (tms_hi_q == 3'(RESET_EDGES - 1)) ? tms_hi_q : tms_hi_q + 3'h1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            fall_pend_q <= 1'b0;
        else if (ev_take)
            fall_pend_q <= 1'b1;
        else if (fall)
            fall_pend_q <= 1'b0;
    end

    // ---------------------------------------------------------------
    // Instruction, bypass, identification and boundary registers
    // ---------------------------------------------------------------
    logic [INSTR_W-1:0] ir_sh_q;
    logic [INSTR_W-1:0] ir_q;
    logic               byp_q;
    logic [ID_W-1:0]    id_q;
    logic [BSR_W-1:0]   bsr_q;
    logic               in_rst;
    logic [BSR_W-1:0]   ring_meta_q;
    logic [BSR_W-1:0]   ring_sync_q;

    assign in_rst = state_q == ST_RESET;

    // ---------------------------------------------------------------
    // Instruction decode, shared by shift, output and memory logic
    // ---------------------------------------------------------------
    // Reserved codes fall through to bypass so a stray code never breaks the chain
    function automatic logic sel_bsr(input logic [INSTR_W-1:0] code);
        sel_bsr = code == INS_EXTEST || code == INS_SAMPLE_Z || code == INS_SAMPLE;
    endfunction

    function automatic logic sel_id(input logic [INSTR_W-1:0] code);
        sel_id = code == INS_IDCODE;
    endfunction

    function automatic logic floats_outputs(input logic [INSTR_W-1:0] code);
        floats_outputs = code == INS_EXTEST || code == INS_SAMPLE_Z;
    endfunction

    // Ring pins cross in through two stages; a word moving mid-capture may mix old and new bits
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ring_meta_q <= '0;
            ring_sync_q <= '0;
        end
        else
        begin
            ring_meta_q <= ring_in;
            ring_sync_q <= ring_meta_q;
        end
    end

    // Reload on the edge that enters reset, so an old code never outlives it
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            ir_q <= INS_RESET_VAL;
        else if (ev_take && state_d == ST_RESET)
            ir_q <= INS_RESET_VAL;
        else if (ev_take && state_q == ST_UPD_IR)
            ir_q <= ir_sh_q;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            ir_sh_q <= INS_RESET_VAL;
        else if (ev_take && state_q == ST_CAP_IR)
            ir_sh_q <= {ir_q[2], IR_CAPTURE};
        else if (ev_take && state_q == ST_SHIFT_IR)
            ir_sh_q <= {ev.tdi, ir_sh_q[INSTR_W-1:1]};
    end

    // Data registers capture on the rise leaving Capture-DR, then shift from the top
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            byp_q <= 1'b0;
        else if (ev_take && state_q == ST_CAP_DR)
            byp_q <= 1'b0;
        else if (ev_take && state_q == ST_SHIFT_DR && !sel_id(ir_q) && !sel_bsr(ir_q))
            byp_q <= ev.tdi;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            id_q <= '0;
        else if (ev_take && state_q == ST_CAP_DR)
            id_q <= ID_CODE;
        else if (ev_take && state_q == ST_SHIFT_DR && sel_id(ir_q))
            id_q <= {ev.tdi, id_q[ID_W-1:1]};
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            bsr_q <= '0;
        else if (ev_take && state_q == ST_CAP_DR)
            bsr_q <= ring_sync_q;
        else if (ev_take && state_q == ST_SHIFT_DR && sel_bsr(ir_q))
            bsr_q <= {ev.tdi, bsr_q[BSR_W-1:1]};
    end

    // ---------------------------------------------------------------
    // Serial output on the falling edge
    // ---------------------------------------------------------------
    logic dr_bit;
    logic shifting;

    always_comb
    begin
        if (sel_id(ir_q))
            dr_bit = id_q[0];
        else if (sel_bsr(ir_q))
            dr_bit = bsr_q[0];
        else
            dr_bit = byp_q;
    end

    assign shifting = state_q == ST_SHIFT_DR || state_q == ST_SHIFT_IR;

    // Shift-IR shows the instruction shifter, every other state the selected data register
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            tdo_o <= 1'b0;
        else if (fall)
            tdo_o <= state_q == ST_SHIFT_IR ? ir_sh_q[0] : dr_bit;
    end

    // Enable follows the same falling edge so data and enable never skew
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            tdo_oe <= 1'b0;
        else if (fall)
            tdo_oe <= shifting && port_on;
    end

    // Memory-side effects only; memory logic never sees the test clock
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            outputs_hiz <= 1'b0;
        else
            outputs_hiz <= port_on && floats_outputs(ir_q);
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            test_reset <= 1'b1;
        else
            test_reset <= in_rst;
    end

endmodule // boundary_scan_test_port

// [verif/scan_port_props.sv]
`timescale 1ns/10ps
module scan_port_props
    import scan_port_pkg::*;
#(
    parameter int BSR_W = 8
) (
    input wire logic             clk_sys,
    input wire logic             reset,
    input wire logic             tck,
    input wire logic             tms,
    input wire logic             tdi,
    input wire logic [BSR_W-1:0] ring_in,
    input wire logic             tdo_o,
    input wire logic             tdo_oe,
    input wire logic             outputs_hiz,
    input wire logic             test_reset
);
    // ----------------------------------------
    // Age of last test clock edges, saturating
    // ----------------------------------------
    logic       tck_q;
    logic [3:0] rise_q;
    logic [3:0] fall_q;

    always_ff @(posedge clk_sys)
    begin
        tck_q <= reset ? 1'b0 : tck;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset) rise_q <= 4'hf;
        else if (tck && !tck_q) rise_q <= 4'h0;
        else if (rise_q != 4'hf) rise_q <= rise_q + 4'h1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset) fall_q <= 4'hf;
        else if (!tck && tck_q) fall_q <= 4'h0;
        else if (fall_q != 4'hf) fall_q <= fall_q + 4'h1;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_out_on_fall;
        ($changed(tdo_o) || $changed(tdo_oe)) |-> fall_q < rise_q;
    endproperty
    a_out_on_fall: assert property (p_out_on_fall) else $error("tdo moved outside a falling edge");

    property p_oe_quiet_reset;
        test_reset |-> !tdo_oe;
    endproperty
    a_oe_quiet_reset: assert property (p_oe_quiet_reset) else $error("tdo driven in reset state");

    property p_release_state;
        $fell(reset) |-> test_reset && !tdo_oe && !tdo_o;
    endproperty
    a_release_state: assert property (p_release_state) else $error("bad state after reset");

    property p_release_ir;
        $fell(reset) |-> !outputs_hiz;
    endproperty
    a_release_ir: assert property (p_release_ir) else $error("instruction not identification");

    property p_ir_steady_shift;
        $changed(outputs_hiz) |-> !tdo_oe;
    endproperty
    a_ir_steady_shift: assert property (p_ir_steady_shift) else $error("instruction moved while shifting");

    property p_tms_reset_ir;
        $rose(test_reset) |-> ##[0:2] !outputs_hiz;
    endproperty
    a_tms_reset_ir: assert property (p_tms_reset_ir) else $error("reset kept old instruction");

    // Settled window: any change here would mean a move without a test clock edge
    property p_idle_quiet;
        (rise_q > 4'h9 && fall_q > 4'h9) |-> $stable(test_reset) && $stable(tdo_oe) && $stable(outputs_hiz);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("state moved with test clock still");

    property p_oe_from_run;
        $rose(tdo_oe) |-> !$past(test_reset);
    endproperty
    a_oe_from_run: assert property (p_oe_from_run) else $error("shift entered from reset state");

    c_shift: cover property ($rose(tdo_oe));
    c_hiz: cover property ($rose(outputs_hiz));
    c_tms_reset: cover property ($rose(test_reset));
endmodule // scan_port_props

bind boundary_scan_test_port scan_port_props #(.BSR_W(BSR_W)) u_props (
    .clk_sys(clk_sys), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .ring_in(ring_in),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .outputs_hiz(outputs_hiz), .test_reset(test_reset)
);

// [verif/scan_master.sv]
`timescale 1ns/10ps
module scan_master (
    input  wire logic clk_sys,
    input  wire logic tdo_o,
    input  wire logic tdo_oe,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    initial
    begin
        tck = 1'b0; // Stands low between frames
        // Data out is only ever read here, never loaded
        tms = 1'b1;
        tdi = 1'b1;
    end

    // ----------------------------------------
    // One test clock of 8 system clocks
    // ----------------------------------------
    // Tdo read just before the rise; a released line reads inverted, never trusted
    task automatic bit_cycle(input logic m, input logic d, output logic o);
        tms <= m;
        tdi <= d;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        o = tdo_oe ? tdo_o : ~tdo_o;
        @(posedge clk_sys);
        tck <= 1'b1;
        repeat (4) @(posedge clk_sys);
        tck <= 1'b0;
    endtask
endmodule // scan_master

// [verif/tb.sv]
`timescale 1ns/10ps
module tb
    import scan_port_pkg::*;
();
    localparam logic [31:0] ID = 32'h1234_5671; // Arbitrary value
    logic       clk_sys, reset, tck, tms, tdi, tdo_o, tdo_oe, outputs_hiz, test_reset, junk;
    logic [7:0] ring_in;
    logic       flat_tdo, flat_oe, flat_hiz, flat_reset;
    int         errors, comparisons;

    initial clk_sys = 1'b0;
    always #12.5 clk_sys = ~clk_sys;

    boundary_scan_test_port #(.BSR_W(8), .HAS_TEST_PORT(1'b1), .ID_CODE(ID)) dut (
        .clk_sys(clk_sys), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .ring_in(ring_in),
        .tdo_o(tdo_o), .tdo_oe(tdo_oe), .outputs_hiz(outputs_hiz), .test_reset(test_reset)
    );
    scan_master scan (.clk_sys(clk_sys), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi));
    // Flat-package build on the same pins: no test port behind them
    boundary_scan_test_port #(.BSR_W(8), .HAS_TEST_PORT(1'b0), .ID_CODE(ID)) dut_flat (
        .clk_sys(clk_sys), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .ring_in(ring_in),
        .tdo_o(flat_tdo), .tdo_oe(flat_oe), .outputs_hiz(flat_hiz), .test_reset(flat_reset)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // From Idle through capture and shift of n bits, back to Idle
    task automatic shift(input bit ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        scan.bit_cycle(1'b1, 1'b1, o);
        if (ir) scan.bit_cycle(1'b1, 1'b1, o);
        scan.bit_cycle(1'b0, 1'b1, o);
        scan.bit_cycle(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++)
        begin
            scan.bit_cycle(i == n - 1, din[i], o);
            dout[i] = o;
        end
        scan.bit_cycle(1'b1, 1'b1, o);
        scan.bit_cycle(1'b0, 1'b1, o);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic chk_reset_values;
        check("test_reset", 32'h1, test_reset);
        check("tdo_oe", 32'h0, tdo_oe);
        check("outputs_hiz", 32'h0, outputs_hiz);
    endtask

    task automatic chk_idcode;
        logic [31:0] d;
        scan.bit_cycle(1'b0, 1'b1, junk);
        shift(1'b0, 32, 32'h0, d);
        check("idcode", ID, d);
        check("tdo_oe idle", 32'h0, tdo_oe);
    endtask

    task automatic chk_bypass;
        logic [31:0] d;
        shift(1'b1, 3, {29'h0, INS_BYPASS}, d);
        check("ir capture", 32'h1, d);
        shift(1'b0, 3, 32'h3, d);
        check("bypass", 32'h6, d);
    endtask

    task automatic chk_boundary;
        logic [31:0] d;
        shift(1'b1, 3, {29'h0, INS_SAMPLE}, d);
        check("ir capture high", 32'h5, d);
        shift(1'b0, 16, 32'hc3, d);
        check("boundary", 32'hc3a5, d);
    endtask

    task automatic chk_modes;
        logic [2:0]  codes [5];
        logic        hiz [5];
        logic [31:0] d;
        codes = '{INS_BYPASS, 3'h3, INS_SAMPLE, INS_SAMPLE_Z, INS_EXTEST};
        hiz = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 5; i++)
        begin
            shift(1'b1, 3, {29'h0, codes[i]}, d);
            repeat (2) @(posedge clk_sys);
            check("outputs_hiz", {31'h0, hiz[i]}, outputs_hiz);
            if (codes[i] == 3'h3)
            begin
                shift(1'b0, 2, 32'h1, d);
                check("reserved path", 32'h2, d);
            end
        end
    endtask

    // From Shift-DR four high edges stop short of reset; the fifth reaches it
    task automatic chk_tms_reset;
        scan.bit_cycle(1'b1, 1'b1, junk);
        scan.bit_cycle(1'b0, 1'b1, junk);
        scan.bit_cycle(1'b0, 1'b1, junk);
        for (int k = 1; k <= RESET_EDGES; k++)
        begin
            scan.bit_cycle(1'b1, 1'b1, junk);
            repeat (2) @(posedge clk_sys);
            check("tms reset", {31'h0, k == RESET_EDGES}, test_reset);
        end
        check("hiz after reset", 32'h0, outputs_hiz);
        chk_idcode;
    endtask

    // Flat build never answers, whatever traffic the shared pins carried
    task automatic chk_flat;
        check("flat tdo_oe", 32'h0, flat_oe);
        check("flat test_reset", 32'h1, flat_reset);
        check("flat outputs_hiz", 32'h0, flat_hiz);
        check("flat tdo_o", 32'h0, flat_tdo);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        reset = 1'b1;
        ring_in = 8'ha5;
        errors = 0;
        comparisons = 0;
        junk = 1'b0;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk_reset_values;
        chk_idcode;
        chk_bypass;
        chk_boundary;
        chk_modes;
        chk_tms_reset;
        chk_flat;
        tally_and_finish;
    end

    initial
    begin
        repeat (100000) @(posedge clk_sys);
        errors++;
        tally_and_finish;
    end
endmodule // tb
